/* File: rtl/ext_bus_pkg.sv */
// Package of constants and carrier types for the external bus interface
package ext_bus_pkg;

  // Address window shared by both chip selects
  localparam logic [31:0] WIN_BASE      = 32'h6000_0000;
  localparam logic [31:0] WIN_LAST      = 32'h61FF_FFFF;
  localparam int          CH_SPAN_BITS  = 24;          // 16MB per channel

  // Field limits
  localparam logic [3:0]  WAIT_MAX      = 4'hF;        // internal waits
  localparam logic [2:0]  LATCH_MAX     = 3'h4;        // latch stretch
  localparam logic [2:0]  SETUP_MAX     = 3'h4;        // setup cycles
  localparam logic [3:0]  RECOV_MAX     = 4'h8;        // recovery clocks

  // Basic cycle lengths in clocks
  localparam logic [2:0]  SEP_BASE_CLKS = 3'h3;
  localparam logic [2:0]  MUX_BASE_CLKS = 3'h4;

  // Reset values
  localparam logic        BUS_MODE_RST  = 1'b0;        // multiplexed
  localparam logic [23:0] ADDR_RST      = 24'h00_0000;

  // Stretch encodings
  typedef enum logic [1:0] {
    STRETCH_X1,
    STRETCH_X2,
    STRETCH_X4
  } stretch_e;

  // Select recovery encodings: 0, 1, 2 or 4 clocks
  typedef enum logic [1:0] {
    CSREC_0,
    CSREC_1,
    CSREC_2,
    CSREC_4
  } cs_recov_e;

  // Per-channel timing configuration
  typedef struct packed {
    logic        wide;        // 1: 16-bit data, 0: 8-bit
    logic [3:0]  wait_cnt;    // internal waits 0..15
    logic [2:0]  latch_cnt;   // latch stretch 0..4
    logic [2:0]  setup_cnt;   // setup cycles 0..4
    logic [3:0]  recov_cnt;   // recovery clocks 0..8
    cs_recov_e   cs_recov;    // select recovery
  } chan_cfg_s;

  // Internal access request
  typedef struct packed {
    logic [31:0] addr;
    logic        write;
    logic [1:0]  lanes;       // byte lanes, bit0 low
    logic [15:0] wdata;
  } req_s;

  // Pin outputs
  typedef struct packed {
    logic [23:0] addr;        // A[23:0], mux mode uses 23:16
    logic [15:0] dout;        // D or AD drive value
    logic        doe;         // data drive enable
    logic        rd_b;
    logic        wr_b;
    logic        bel_b;       // low byte enable
    logic        beh_b;       // high byte enable
    logic        cs0_b;
    logic        cs1_b;
    logic        latch;       // address latch strobe
  } pins_s;

endpackage

/* File: rtl/stretch_count.sv */
// Scales a configured cycle count by the bus expansion factor
`timescale 1ns/1ps
module stretch_count #(
  parameter int W = 4
) (
  input  wire logic [W-1:0]           raw,
  input  ext_bus_pkg::stretch_e       mult,
  output logic      [W+1:0]           scaled
);
  // Shift left by 0, 1 or 2; width grows by two so nothing drops
  always_comb begin
    case (mult)
      ext_bus_pkg::STRETCH_X2: scaled = {1'b0, raw, 1'b0};
      ext_bus_pkg::STRETCH_X4: scaled = {raw, 2'b00};
      default:                 scaled = {2'b00, raw};
    endcase
  end
endmodule // stretch_count

/* File: rtl/ext_bus_if.sv */
// External asynchronous bus interface with two chip selects
`timescale 1ns/1ps
// Function
// R1: Separate buses when mode 1, multiplexed when 0
// R2: Per-channel data width, 8 or 16 bits
// R3: Two selects decoded in the shared window; the code takes the select from ch_sel, not from the address
// R4: Up to 15 internal wait cycles per channel
// R5: Latch strobe stretch up to 4 cycles
// R6: Setup cycles before read or write strobe
// R7: Recovery dummy cycle up to 8 clocks
// R8: Expansion multiplies waits by two or four
// R9: Separate mode drives data, address, strobes, selects
// R10: Multiplexed mode shares lines, adds latch strobe
// R11: Internal access keeps address, floats data
// R12: Separate basic cycle takes three clocks
// R13: Multiplexed basic cycle takes four clocks
// R14: Internal access: no latch, float, strobes idle
// R15: Select recovery of 0, 1, 2 or 4 clocks
module ext_bus_if (
  input  wire logic                   clk,
  input  wire logic                   rst_b,
  input  wire logic                   bus_mode_control,  // 1 separate
  input  ext_bus_pkg::stretch_e       stretch,
  input  ext_bus_pkg::chan_cfg_s      cfg0,
  input  ext_bus_pkg::chan_cfg_s      cfg1,
  input  wire logic                   ch_sel,   // channel for the window
  input  wire logic                   req_valid,
  input  ext_bus_pkg::req_s           req,
  output logic                        req_ready,
  output logic                        rsp_valid,
  output logic      [15:0]            rsp_rdata,
  input  wire logic [15:0]            din,
  output ext_bus_pkg::pins_s          pins
);

  // Sequencer phases
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_LATCH,
    ST_SETUP,
    ST_STROBE,
    ST_HOLD,
    ST_RECOV
  } phase_e;

  // Window decode, used for request taking only; the select comes from ch_sel
  function automatic logic in_window(input logic [31:0] a);
    in_window = (a >= ext_bus_pkg::WIN_BASE) &&
                (a <= ext_bus_pkg::WIN_LAST);
  endfunction

  phase_e                    phase_q;      // Current phase
  logic   [5:0]              cnt_q;        // Phase down counter
  ext_bus_pkg::chan_cfg_s    cfg;          // Active channel config
  ext_bus_pkg::req_s         cur_q;        // Captured request
  logic                      ch_q;         // Captured channel
  logic                      mode_q;       // Mode frozen for the cycle
  logic                      hi_q;         // Second byte of 8-bit split
  logic                      split_q;      // Split needed
  logic   [7:0]              lo_byte_q;    // First byte read when split
  logic   [5:0]              wait_s;       // Scaled waits
  logic   [4:0]              latch_s;      // Scaled latch stretch
  logic   [4:0]              setup_s;      // Scaled setup
  logic   [5:0]              recov_s;      // Scaled recovery
  logic   [2:0]              csrec;        // Select recovery clocks
  logic                      take;         // Request accepted

  // Config follows the captured channel once a cycle is running
  assign cfg  = (phase_q == ST_IDLE ? ch_sel : ch_q) ? cfg1 : cfg0;
  assign take = (phase_q == ST_IDLE) && req_valid && in_window(req.addr);

  // Expansion scaling of all stretchable counts, see R8
  stretch_count #(.W(4)) u_wait (
    .raw(cfg.wait_cnt), .mult(stretch), .scaled(wait_s));
  stretch_count #(.W(3)) u_latch (
    .raw(cfg.latch_cnt), .mult(stretch), .scaled(latch_s));
  stretch_count #(.W(3)) u_setup (
    .raw(cfg.setup_cnt), .mult(stretch), .scaled(setup_s));
  stretch_count #(.W(4)) u_recov (
    .raw(cfg.recov_cnt), .mult(stretch), .scaled(recov_s));

  // Select recovery decode, see R15
  always_comb begin
    case (cfg.cs_recov)
      ext_bus_pkg::CSREC_1: csrec = 3'h1;
      ext_bus_pkg::CSREC_2: csrec = 3'h2;
      ext_bus_pkg::CSREC_4: csrec = 3'h4;
      default:              csrec = 3'h0;
    endcase
  end

  // Ready only when idle; out-of-window addresses are internal
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      req_ready <= 1'b0;
    end else begin
      req_ready <= (phase_q == ST_IDLE) && !take;
    end
  end

  // Request capture
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cur_q   <= '0;
      ch_q    <= 1'b0;
      mode_q  <= ext_bus_pkg::BUS_MODE_RST;
      split_q <= 1'b0;
    end else if (take) begin
      cur_q   <= req;
      ch_q    <= ch_sel;
      mode_q  <= bus_mode_control;
      // 8-bit channel splits a two-lane access, see R2
      split_q <= !cfg.wide && (req.lanes == 2'b11);
    end
  end

  // Phase sequencer. Base strobe is 1 clock after 1 address clock;
  // multiplexed adds 1 latch clock ahead of it: 3 or 4 in total.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      phase_q <= ST_IDLE;
      cnt_q   <= '0;
      hi_q    <= 1'b0;
    end else begin
      case (phase_q)
        ST_IDLE: begin
          if (take) begin
            hi_q <= 1'b0;
            if (bus_mode_control) begin
              // One address clock, then setup, see R12
              phase_q <= ST_SETUP;
              cnt_q   <= {1'b0, setup_s};   // see R6
            end else begin
              // One latch clock plus stretch, see R13 R5
              phase_q <= ST_LATCH;
              cnt_q   <= {1'b0, latch_s};
            end
          end
        end
        ST_LATCH: begin
          if (cnt_q == 6'h00) begin
            phase_q <= ST_SETUP;
            cnt_q   <= {1'b0, setup_s};     // see R6
          end else begin
            cnt_q <= cnt_q - 6'h01;
          end
        end
        ST_SETUP: begin
          if (cnt_q == 6'h00) begin
            phase_q <= ST_STROBE;
            cnt_q   <= wait_s;              // see R4
          end else begin
            cnt_q <= cnt_q - 6'h01;
          end
        end
        ST_STROBE: begin
          if (cnt_q == 6'h00) begin
            phase_q <= ST_HOLD;
          end else begin
            cnt_q <= cnt_q - 6'h01;
          end
        end
        ST_HOLD: begin
          // Recovery is the larger of strobe and select recovery
          phase_q <= ST_RECOV;
          cnt_q   <= (recov_s > {3'h0, csrec}) ?
                     recov_s : {3'h0, csrec};          // see R7 R15
        end
        ST_RECOV: begin
          // Counter reaching zero gives exactly the chosen extra clocks
          if (cnt_q == 6'h00) begin
            if (split_q && !hi_q) begin
              // Second byte of an 8-bit split access, see R2
              hi_q    <= 1'b1;
              phase_q <= mode_q ? ST_SETUP : ST_LATCH;
              cnt_q   <= mode_q ? {1'b0, setup_s}
                                : {1'b0, latch_s};
            end else begin
              phase_q <= ST_IDLE;
            end
          end else begin
            cnt_q <= cnt_q - 6'h01;
          end
        end
        default: phase_q <= ST_IDLE;
      endcase
    end
  end

  // Read data capture at end of strobe; split joins two bytes
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rsp_valid <= 1'b0;
      rsp_rdata <= '0;
      lo_byte_q <= '0;
    end else begin
      rsp_valid <= 1'b0;
      if (phase_q == ST_STROBE && cnt_q == 6'h00) begin
        if (split_q && !hi_q) begin
          lo_byte_q <= din[7:0];
        end else begin
          rsp_valid <= 1'b1;
          if (split_q) begin
            rsp_rdata <= {din[7:0], lo_byte_q};          // see R2
          end else if (!cfg.wide) begin
            // Narrow lane: byte always on low lines
            rsp_rdata <= cur_q.lanes[1] ? {din[7:0], 8'h00}
                                        : {8'h00, din[7:0]};
          end else begin
            rsp_rdata <= din;
          end
        end
      end
    end
  end

  // Pin drive. Address lines hold the last external address between
  // accesses, data floats when idle, see R11 R14
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pins.addr  <= ext_bus_pkg::ADDR_RST;
      pins.dout  <= '0;
      pins.doe   <= 1'b0;
      pins.rd_b  <= 1'b1;
      pins.wr_b  <= 1'b1;
      pins.bel_b <= 1'b1;
      pins.beh_b <= 1'b1;
      pins.cs0_b <= 1'b1;
      pins.cs1_b <= 1'b1;
      pins.latch <= 1'b0;
    end else begin
      case (phase_q)
        ST_IDLE: begin
          pins.doe   <= 1'b0;                           // see R11
          pins.rd_b  <= 1'b1;                           // see R14
          pins.wr_b  <= 1'b1;
          pins.latch <= 1'b0;
          pins.cs0_b <= 1'b1;
          pins.cs1_b <= 1'b1;
          pins.bel_b <= 1'b1;
          pins.beh_b <= 1'b1;
          if (take) begin
            // Address phase; first byte of a split uses the request address unchanged
            pins.addr  <= req.addr[ext_bus_pkg::CH_SPAN_BITS-1:0];
            pins.cs0_b <= ch_sel;                       // see R3
            pins.cs1_b <= !ch_sel;
            if (!bus_mode_control) begin
              // Low address on shared lines, see R1 R10
              pins.dout  <= req.addr[15:0];
              pins.doe   <= 1'b1;
              pins.latch <= 1'b1;
            end
          end
        end
        ST_LATCH: begin
          pins.latch <= (cnt_q != 6'h00);               // see R5
          pins.doe   <= (cnt_q != 6'h00);
        end
        ST_SETUP: begin
          pins.latch <= 1'b0;
          if (hi_q) begin
            pins.addr[0] <= 1'b1;
          end
          // Data drive for writes, otherwise float, see R9
          pins.doe   <= cur_q.write;
          pins.dout  <= (split_q && hi_q) ? {8'h00, cur_q.wdata[15:8]}
                                          : cur_q.wdata;
          pins.bel_b <= !(cur_q.lanes[0] && !hi_q) &&
                        !(split_q && hi_q);
          pins.beh_b <= !(cur_q.lanes[1] && cfg.wide);
          if (cnt_q == 6'h00) begin
            pins.rd_b <= cur_q.write;
            pins.wr_b <= !cur_q.write;
          end
        end
        ST_STROBE: begin
          if (cnt_q == 6'h00) begin
            pins.rd_b <= 1'b1;
            pins.wr_b <= 1'b1;
          end
        end
        ST_HOLD: begin
          pins.doe   <= 1'b0;
          pins.cs0_b <= 1'b1;
          pins.cs1_b <= 1'b1;
          pins.bel_b <= 1'b1;
          pins.beh_b <= 1'b1;
        end
        ST_RECOV: begin
          pins.doe <= 1'b0;
          if (cnt_q == 6'h00 && split_q && !hi_q) begin
            // Odd byte address settles before its strobe, see R2
            pins.addr[0] <= 1'b1;
            pins.cs0_b <= ch_q;
            pins.cs1_b <= !ch_q;
            if (!mode_q) begin
              pins.dout  <= {cur_q.addr[15:1], 1'b1};
              pins.doe   <= 1'b1;
              pins.latch <= 1'b1;
            end
          end
        end
        default: pins.doe <= 1'b0;
      endcase
    end
  end

endmodule // ext_bus_if

/* File: bench/ext_bus_if_chk.sv */
// Assertion checker for the external bus interface
`timescale 1ns/1ps
module ext_bus_chk (
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic              bus_mode_control,
  input  ext_bus_pkg::stretch_e  stretch,
  input  ext_bus_pkg::chan_cfg_s cfg0,
  input  ext_bus_pkg::chan_cfg_s cfg1,
  input  wire logic              ch_sel,
  input  wire logic              req_valid,
  input  ext_bus_pkg::req_s      req,
  input  wire logic              req_ready,
  input  wire logic              rsp_valid,
  input  wire logic [15:0]       rsp_rdata,
  input  wire logic [15:0]       din,
  input  ext_bus_pkg::pins_s     pins
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic                   hit;    // Address inside the window
  logic                   take;   // Request accepted this edge
  logic                   zero;   // No added cycles before the response
  ext_bus_pkg::chan_cfg_s c;      // Config of the picked channel
  logic [6:0]             exp_d;  // Added cycles, scaled
  logic [6:0]             cnt_q;
  logic [6:0]             exp_q;
  assign hit = req.addr >= ext_bus_pkg::WIN_BASE &&
               req.addr <= ext_bus_pkg::WIN_LAST;
  assign take = req_valid && req_ready && hit;
  assign c = ch_sel ? cfg1 : cfg0;
  // Shift by the enum code gives factor one, two or four
  assign exp_d = (7'(c.wait_cnt) + 7'(c.setup_cnt)) << stretch;
  assign zero = c.wide && exp_d == 7'h00 && c.latch_cnt == 3'h0;
  // Cycle counter from take; only wide separate cycles are judged
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= 7'h00;
      exp_q <= 7'h00;
    end else if (take) begin
      cnt_q <= 7'h01;
      exp_q <= (bus_mode_control && c.wide) ? exp_d + 7'h03 : 7'h00;
    end else if (rsp_valid) begin
      cnt_q <= 7'h00;
    end else if (cnt_q != 7'h00) begin
      cnt_q <= cnt_q + 7'h01;
    end
  end
  idle_quiet_a:
    assert property (req_ready |-> pins.rd_b && pins.wr_b && !pins.latch)
    else $error("strobe active while idle");
  strobe_excl_a:
    assert property (!(!pins.rd_b && !pins.wr_b))
    else $error("read and write strobes both active");
  sel_excl_a:
    assert property (!(!pins.cs0_b && !pins.cs1_b))
    else $error("both selects active");
  read_float_a:
    assert property (!pins.rd_b |-> !pins.doe)
    else $error("data driven during read");
  sep_basic_a:
    assert property (take && bus_mode_control && zero |-> ##3 rsp_valid)
    else $error("separate cycle not three clocks");
  mux_basic_a:
    assert property (take && !bus_mode_control && zero |-> ##4 rsp_valid)
    else $error("multiplexed cycle not four clocks");
  rsp_pulse_a:
    assert property (rsp_valid |=> !rsp_valid)
    else $error("response longer than one cycle");
  outside_keep_a:
    assert property (req_valid && req_ready && !hit |=>
                     req_ready && $stable(pins.addr) && !pins.doe)
    else $error("internal access disturbed the pins");
  cycle_len_a:
    assert property (rsp_valid && exp_q != 7'h00 |-> cnt_q == exp_q)
    else $error("wait or setup count wrong");
  cover property (take && bus_mode_control);
  cover property (take && !bus_mode_control);
  cover property (take && stretch == ext_bus_pkg::STRETCH_X4);
endmodule // ext_bus_chk
bind ext_bus_if ext_bus_chk chk (.clk(clk), .rst_b(rst_b),
  .bus_mode_control(bus_mode_control), .stretch(stretch), .cfg0(cfg0),
  .cfg1(cfg1), .ch_sel(ch_sel), .req_valid(req_valid), .req(req),
  .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
  .din(din), .pins(pins));

/* File: bench/ext_mem_model.sv */
// Behavioural asynchronous memory on the far side of the bus
`timescale 1ns/1ps
module ext_mem_model (
  input  wire logic          clk,
  input  wire logic          bus_mode_control,
  input  wire logic [1:0]    wide,   // Width per select, bit1 for one
  input  ext_bus_pkg::pins_s pins,
  output logic      [15:0]   din
);
  logic [7:0]  mem [32];  // Byte storage, low address bits only
  logic [4:0]  lat_q;     // Address caught by the latch strobe
  logic [4:0]  a;
  logic [15:0] last_q;
  logic        sel;
  logic        w;
  assign sel = !pins.cs0_b || !pins.cs1_b;
  assign w = pins.cs0_b ? wide[1] : wide[0];
  assign a = bus_mode_control ? pins.addr[4:0] : lat_q;
  // Released lines show the inverse, so stale data never matches
  assign din = (sel && !pins.rd_b) ? {mem[a | 5'h01], mem[a]} : ~last_q;
  // Latch capture and strobed writes
  always @(posedge clk) begin
    last_q <= din;
    if (pins.latch) begin
      lat_q <= pins.dout[4:0];
    end
    if (sel && !pins.wr_b) begin
      if (!w) begin
        mem[a] <= pins.dout[7:0];
      end else begin
        if (!pins.bel_b) mem[a] <= pins.dout[7:0];
        if (!pins.beh_b) mem[a | 5'h01] <= pins.dout[15:8];
      end
    end
  end
endmodule // ext_mem_model

/* File: bench/test_ext_bus_if.sv */
// Self-checking bench for the external bus interface
`timescale 1ns/1ps
module test_ext_bus_if;
  logic                   clk = 1'b0;
  logic                   rst_b = 1'b0;
  logic                   mode = 1'b1;
  ext_bus_pkg::stretch_e  stretch = ext_bus_pkg::STRETCH_X1;
  ext_bus_pkg::chan_cfg_s cfg0 = ext_bus_pkg::chan_cfg_s'(17'h10000);
  ext_bus_pkg::chan_cfg_s cfg1 = ext_bus_pkg::chan_cfg_s'(17'h10000);
  logic                   ch_sel = 1'b0;
  logic                   req_valid = 1'b0;
  ext_bus_pkg::req_s      req = '0;
  logic                   req_ready;
  logic                   rsp_valid;
  logic [15:0]            rsp_rdata;
  logic [15:0]            din;
  ext_bus_pkg::pins_s     pins;
  int                     error_cnt = 0;
  int                     checks = 0;
  int                     n;    // Edges from take to response
  int                     g;    // Edges from response to idle
  int                     b;
  logic [15:0]            rd;
  always #2 clk = ~clk;
  ext_bus_if uut (.clk(clk), .rst_b(rst_b), .bus_mode_control(mode),
    .stretch(stretch), .cfg0(cfg0), .cfg1(cfg1), .ch_sel(ch_sel),
    .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .din(din), .pins(pins));
  ext_mem_model mem (.clk(clk), .bus_mode_control(mode),
    .wide({cfg1.wide, cfg0.wide}), .pins(pins), .din(din));
  // Verdict and end of run
  task automatic final_report();
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One access held until taken; every wait is bounded
  task automatic acc(input logic [31:0] ad, input logic wr,
                     input logic [15:0] wd);
    int k;
    req <= '{ad, wr, 2'h3, wd};
    req_valid <= 1'b1;
    k = 0;
    do begin @(posedge clk); k++; end while (!req_ready && k < 200);
    req_valid <= 1'b0;
    n = 0;
    do begin @(posedge clk); n++; end while (!rsp_valid && n < 200);
    rd = rsp_rdata;
    g = 0;
    do begin @(posedge clk); g++; end while (!req_ready && g < 200);
    if (k >= 200 || n >= 200 || g >= 200) begin
      error_cnt++;
      final_report();
    end
  endtask
  task automatic t_sep();
    acc(32'h6000_0004, 1'b1, 16'hA55A);
    cmp(16'(n), 16'h0003);
    acc(32'h6000_0004, 1'b0, 16'h0000);
    cmp(rd, 16'hA55A);
  endtask
  // Largest wait plus setup under each expansion factor
  task automatic t_waits();
    for (int s = 0; s < 3; s++) begin
      stretch <= ext_bus_pkg::stretch_e'(s);
      cfg0.wait_cnt <= 4'hF;
      cfg0.setup_cnt <= 3'h4;
      acc(32'h6000_0004, 1'b0, 16'h0000);
      cmp(16'(n), 16'(3 + (19 << s)));
      cmp(rd, 16'hA55A);
    end
    stretch <= ext_bus_pkg::STRETCH_X1;
    cfg0.wait_cnt <= 4'h0;
    cfg0.setup_cnt <= 3'h0;
  endtask
  // Gap to idle grows by exactly the recovery chosen
  task automatic t_recov();
    acc(32'h6000_0004, 1'b0, 16'h0000);
    b = g;
    for (int i = 0; i < 4; i++) begin
      cfg0.cs_recov <= ext_bus_pkg::cs_recov_e'(i);
      acc(32'h6000_0004, 1'b0, 16'h0000);
      cmp(16'(g - b), (i == 3) ? 16'h0004 : 16'(i));
    end
    cfg0.cs_recov <= ext_bus_pkg::CSREC_0;
    cfg0.recov_cnt <= 4'h8;
    acc(32'h6000_0004, 1'b0, 16'h0000);
    cmp(16'(g - b), 16'h0008);
    cfg0.recov_cnt <= 4'h0;
  endtask
  // Byte channel pairs two cycles, low byte first
  task automatic t_narrow();
    cfg0.wide <= 1'b0;
    acc(32'h6000_0004, 1'b0, 16'h0000);
    cmp(rd, 16'hA55A);
    acc(32'h6000_000C, 1'b1, 16'hC3E1);
    cfg0.wide <= 1'b1;
    acc(32'h6000_000C, 1'b0, 16'h0000);
    cmp(rd, 16'hC3E1);
  endtask
  // Internal access: pins stay quiet, last address held
  task automatic t_internal();
    req <= '{32'h2000_0000, 1'b0, 2'h3, 16'h0000};
    req_valid <= 1'b1;
    repeat (8) begin
      @(posedge clk);
      cmp({rsp_valid, pins.cs0_b, pins.cs1_b, pins.doe, pins.rd_b,
           pins.wr_b, pins.latch}, 16'h0036);
      cmp(pins.addr[15:0], 16'h000C);
    end
    req_valid <= 1'b0;
  endtask
  // Multiplexed on select one, then a stretched latch
  task automatic t_mux();
    mode <= 1'b0;
    ch_sel <= 1'b1;
    acc(32'h6000_0008, 1'b1, 16'h1234);
    cmp(16'(n), 16'h0004);
    acc(32'h6000_0008, 1'b0, 16'h0000);
    cmp(rd, 16'h1234);
    cfg1.latch_cnt <= 3'h4;
    acc(32'h6000_0008, 1'b0, 16'h0000);
    cmp(16'(n), 16'h0008);
  endtask
  initial begin
    repeat (8) @(posedge clk);
    cmp({pins.cs0_b, pins.cs1_b, pins.rd_b, pins.wr_b, pins.latch,
         pins.doe}, 16'h003C);
    rst_b <= 1'b1;
    @(posedge clk);
    t_sep();
    t_waits();
    t_recov();
    t_narrow();
    t_internal();
    t_mux();
    final_report();
  end
endmodule // test_ext_bus_if
